// [verilog/cal_regs.sv]
// Top: channel 7 configuration and calibration register bank with an
// AXI4-Lite slave and the correction datapath.
// Assumes one clock, asynchronous active-low reset, and that the CRC value
// is computed elsewhere and presented on checksum_value.
//
// Operation
// - Config bits 15:6 hold a signed modulator-cycle phase delay, reset 0.
// - Config bit 2 low follows the global DC block, high disables it here.
// - Input select 00 pins, 01 shorted, 10 positive, 11 negative test.
// - Offset bits 23:8 fill the offset high register, two's complement.
// - Offset bits 7:0 sit in offset low bits 15:8; bits 7:0 read zero.
// - Gain is unsigned below 2.0; bits 23:8 fill the gain high register.
// - Gain bits 7:0 sit in gain low bits 15:8; its low byte reads zero.
// - Gain high resets to 8000h, gain low and both offsets to zero.
// - Checksum at 3Eh is read-only, resets to zero and ignores writes.
module cal_regs
    import cal_regs_pkg::*;
#(
    parameter int ADDR_W = ADDR_WIDTH
)(
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Surrounding converter
    input  wire logic                     global_dc_block_setting,
    input  wire logic [15:0]              checksum_value,
    input  wire logic                     checksum_load,
    input  wire logic                     raw_valid,
    input  wire logic signed [23:0]       raw_data,
    output logic                          out_valid,
    output logic signed [23:0]            out_data,
    output logic signed [9:0]             ch7_phase_delay,
    output logic                          ch7_dc_block_on,
    output logic                          ch7_use_pins,
    output logic                          ch7_short_inputs,
    output logic                          ch7_test_pos,
    output logic                          ch7_test_neg
);
    // Elaboration checks: the word index needs eight address bits, and
    // the phase field must match the ten-bit phase output
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end
    if (PHASE_MSB - PHASE_LSB != 9) begin : g_phase_check
        $error("phase field must be ten bits wide");
    end

    typedef struct packed {
        logic [15:0] config_val;
        logic [15:0] offset_high;
        logic [7:0]  offset_low;
        logic [15:0] gain_high;
        logic [7:0]  gain_low;
        logic [15:0] checksum;
        logic        aw_held;
        logic [5:0]  aw_idx;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } regs_state_t;

    regs_state_t st_reg;
    regs_state_t st_next;
    logic        rd_hit;
    logic [15:0] rd_word;
    logic [5:0]  ar_idx;

    // Word index from a byte address
    function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
        return a[7:2];
    endfunction : word_idx

    // True when the index names a register of this bank
    function automatic logic is_mapped(input logic [5:0] idx);
        return idx == IDX_CONFIG || idx == IDX_OFFSET_HIGH ||
               idx == IDX_OFFSET_LOW || idx == IDX_GAIN_HIGH ||
               idx == IDX_GAIN_LOW || idx == IDX_CHECKSUM;
    endfunction : is_mapped

    // Byte-lane merge of write data into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [15:0] mask);
        return (old & ~mask) | (val & mask);
    endfunction : merge

    // Config bits that are reserved and always read as zero
    localparam logic [15:0] CFG_RSVD_MASK =
        16'((1 << (RESERVED_MSB + 1)) - (1 << RESERVED_LSB));

    // Read value; reserved bits read as zero
    always_comb begin
        ar_idx = word_idx(s_axi_araddr);
        rd_hit = is_mapped(ar_idx);
        case (ar_idx)
            IDX_CONFIG:      rd_word = st_reg.config_val & ~CFG_RSVD_MASK;
            IDX_OFFSET_HIGH: rd_word = st_reg.offset_high;
            IDX_OFFSET_LOW:  rd_word = {st_reg.offset_low, 8'h00};
            IDX_GAIN_HIGH:   rd_word = st_reg.gain_high;
            IDX_GAIN_LOW:    rd_word = {st_reg.gain_low, 8'h00};
            IDX_CHECKSUM:    rd_word = st_reg.checksum;
            default:         rd_word = 16'h0000;
        endcase
    end

    // Bus handshakes and register updates
    always_comb begin
        logic [15:0] wv;
        logic [15:0] wm;
        wv = 16'h0000;
        wm = 16'h0000;
        st_next = st_reg;
        if (s_axi_awvalid && !st_reg.aw_held) begin
            st_next.aw_held = 1'b1;
            st_next.aw_idx  = word_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && !st_reg.w_held) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // Commit once address and data are both held and no response waits
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = is_mapped(st_reg.aw_idx) ? RESP_OKAY
                                                       : RESP_SLVERR;
            wm = {{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
            wv = (st_reg.w_data[15:0] & wm);
            case (st_reg.aw_idx)
                IDX_CONFIG: begin
                    // Reserved bits never take a written one
                    st_next.config_val =
                        merge(st_reg.config_val, wv, wm) & ~CFG_RSVD_MASK;
                end
                IDX_OFFSET_HIGH:
                    st_next.offset_high = merge(st_reg.offset_high, wv, wm);
                IDX_OFFSET_LOW: if (st_reg.w_strb[1])
                    st_next.offset_low = wv[15:8];
                IDX_GAIN_HIGH:
                    st_next.gain_high = merge(st_reg.gain_high, wv, wm);
                IDX_GAIN_LOW: if (st_reg.w_strb[1])
                    st_next.gain_low = wv[15:8];
                default: ;                     // Checksum writes ignored
            endcase
        end
        // Checksum comes only from the CRC engine
        if (checksum_load) begin
            st_next.checksum = checksum_value;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = {16'h0000, rd_word};
            st_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg             <= '0;
            st_reg.config_val  <= CONFIG_RESET;
            st_reg.offset_high <= OFFSET_HIGH_RESET;
            st_reg.offset_low  <= OFFSET_LOW_RESET;
            st_reg.gain_high   <= GAIN_HIGH_RESET;
            st_reg.gain_low    <= GAIN_LOW_RESET;
            st_reg.checksum    <= CHECKSUM_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Handshake outputs
    assign s_axi_awready = !st_reg.aw_held;
    assign s_axi_wready  = !st_reg.w_held;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

    // Channel controls
    assign ch7_phase_delay =
        $signed(st_reg.config_val[PHASE_MSB:PHASE_LSB]);
    assign ch7_dc_block_on = !st_reg.config_val[DC_BLOCK_OFF_BIT]
                             && global_dc_block_setting;

    // Route decode: one flag per input selection code, exactly one high
    logic [3:0] route;
    for (genvar k = 0; k < 4; k++) begin : g_route
        assign route[k] = st_reg.config_val[INPUT_SEL_MSB:INPUT_SEL_LSB]
                          == 2'(k);
    end
    assign ch7_use_pins     = route[SEL_PINS];
    assign ch7_short_inputs = route[SEL_SHORTED];
    assign ch7_test_pos     = route[SEL_TEST_POS];
    assign ch7_test_neg     = route[SEL_TEST_NEG];

    cal_apply_if cal_bus ();
    assign cal_bus.offset = $signed({st_reg.offset_high, st_reg.offset_low});
    assign cal_bus.gain   = {st_reg.gain_high, st_reg.gain_low};

    cal_correct u_correct (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .cal       (cal_bus.path),
        .raw_valid (raw_valid),
        .raw_data  (raw_data),
        .out_valid (out_valid),
        .out_data  (out_data)
    );
endmodule : cal_regs

// [verilog/cal_regs_pkg.sv]
// Package: register map, field layout, reset values and datapath constants
// for the channel 7 calibration register bank.
// Assumes a 32-bit AXI4-Lite register bus; printed offsets are word indices.
package cal_regs_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [5:0]  IDX_CONFIG      = 6'h2c;
    localparam logic [5:0]  IDX_OFFSET_HIGH = 6'h2d;
    localparam logic [5:0]  IDX_OFFSET_LOW  = 6'h2e;
    localparam logic [5:0]  IDX_GAIN_HIGH   = 6'h2f;
    localparam logic [5:0]  IDX_GAIN_LOW    = 6'h30;
    localparam logic [5:0]  IDX_CHECKSUM    = 6'h3e;
    localparam int          ADDR_WIDTH      = 8;

    // Configuration field positions
    localparam int          PHASE_MSB       = 15;
    localparam int          PHASE_LSB       = 6;
    localparam int          DC_BLOCK_OFF_BIT = 2;
    localparam int          INPUT_SEL_MSB   = 1;
    localparam int          INPUT_SEL_LSB   = 0;
    localparam int          RESERVED_MSB    = 5;
    localparam int          RESERVED_LSB    = 3;
    localparam int          LOW_BYTE_MSB    = 15;
    localparam int          LOW_BYTE_LSB    = 8;

    // Reset values
    localparam logic [15:0] CONFIG_RESET      = 16'h0000;
    localparam logic [15:0] OFFSET_HIGH_RESET = 16'h0000;
    localparam logic [7:0]  OFFSET_LOW_RESET  = 8'h00;
    localparam logic [15:0] GAIN_HIGH_RESET   = 16'h8000;
    localparam logic [7:0]  GAIN_LOW_RESET    = 8'h00;
    localparam logic [15:0] CHECKSUM_RESET    = 16'h0000;

    // Gain scaling: 800000h is unity, so the product shifts right by 23
    localparam int          GAIN_FRAC_BITS  = 23;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // Input routing choices
    typedef enum logic [1:0] {
        SEL_PINS, SEL_SHORTED, SEL_TEST_POS, SEL_TEST_NEG
    } input_sel_t;

endpackage : cal_regs_pkg

// [verilog/cal_apply_if.sv]
// Interface: calibration values passed from the register bank to the
// correction datapath.
// Assumes both ends share sys_clk.
interface cal_apply_if;
    logic signed [23:0] offset;
    logic        [23:0] gain;

    modport regs (output offset, output gain);
    modport path (input  offset, input  gain);
endinterface : cal_apply_if

// [verilog/cal_correct.sv]
// Correction datapath: subtracts offset, then scales by gain.
// Assumes a raw sample strobe synchronous to sys_clk.
module cal_correct
    import cal_regs_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    cal_apply_if.path               cal,
    input  wire logic               raw_valid,
    input  wire logic signed [23:0] raw_data,
    output logic                    out_valid,
    output logic signed [23:0]      out_data
);
    typedef struct packed {
        logic               valid;
        logic signed [23:0] data;
    } path_state_t;

    path_state_t        st_reg;
    path_state_t        st_next;
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] scaled;

    // Offset removal, gain scaling, saturation to 24 bits
    always_comb begin
        st_next       = st_reg;
        st_next.valid = raw_valid;
        diff   = 25'(raw_data) - 25'(cal.offset);
        prod   = 50'(diff) * $signed({1'b0, cal.gain});
        scaled = prod >>> GAIN_FRAC_BITS;
        if (raw_valid) begin
            if (scaled > 50'sh7fffff) begin
                st_next.data = 24'sh7fffff;
            end else if (scaled < -50'sh800000) begin
                st_next.data = -24'sh800000;
            end else begin
                st_next.data = scaled[23:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_valid = st_reg.valid;
    assign out_data  = st_reg.data;
endmodule : cal_correct

// [testbench/cal_regs_asserts.sv]
// Checker: bus read handshake, decode and datapath timing of cal_regs.
// Assumes it is bound to cal_regs and sees only its ports.
module cal_regs_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        global_dc_block_setting,
    input wire logic        raw_valid,
    input wire logic        out_valid,
    input wire logic        ch7_dc_block_on,
    input wire logic        ch7_use_pins,
    input wire logic        ch7_short_inputs,
    input wire logic        ch7_test_pos,
    input wire logic        ch7_test_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks sample on sys_clk and rest during reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer missing");
    chk_read_done: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read answer repeated");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before taken");
    chk_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
    ) else $error("upper read half not zero");
    chk_out_timing: assert property (raw_valid |=> out_valid)
        else $error("corrected sample late");
    chk_out_pulse: assert property (!raw_valid |=> !out_valid)
        else $error("corrected sample without input");
    chk_dc_follow: assert property (
        ch7_dc_block_on |-> global_dc_block_setting
    ) else $error("dc block on against global setting");
    chk_sel_onehot: assert property ($onehot({ch7_use_pins,
        ch7_short_inputs, ch7_test_pos, ch7_test_neg}))
        else $error("input route not one-hot");
endmodule : cal_regs_asserts

bind cal_regs cal_regs_asserts u_cal_regs_asserts (.*);

// [testbench/host_bus_model.sv]
// Partner: host side AXI4-Lite master issuing single accesses.
// Assumes the slave shares sys_clk; only the bench timeout ends a wait.
module host_bus_model (
    input  wire logic        sys_clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero; every byte lane enabled
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
    end

    // Offer address and data together, drop each when taken, await b
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] be, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= be;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) ||
                   (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : write_reg

    // Hold the read request until taken, then wait for the answer
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : read_reg
endmodule : host_bus_model

// [testbench/test_cal_regs.sv]
// Testbench: reset values, access kinds, decode outputs and datapath.
// Assumes package, design, checker and host model compile before it.
module test_cal_regs;
    import cal_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic               sys_clk = 1'b0;
    logic               rst_b = 1'b0;
    logic [7:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]         s_axi_wstrb;
    logic [1:0]         s_axi_bresp, s_axi_rresp, resp;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic               s_axi_rready, checksum_load, raw_valid, out_valid;
    logic               global_dc_block_setting, ch7_dc_block_on;
    logic               ch7_use_pins, ch7_short_inputs;
    logic               ch7_test_pos, ch7_test_neg;
    logic [15:0]        checksum_value;
    logic signed [23:0] raw_data, out_data;
    logic signed [9:0]  ch7_phase_delay;
    int                 miscompares = 0;
    int                 checks = 0;
    int                 cycles = 0;

    cal_regs u_cal_regs (.*);
    host_bus_model u_host_bus_model (.*);

    always #2 sys_clk = ~sys_clk;
    // Cycle ceiling against a hung handshake
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [5:0] i, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY,
                      input logic [3:0] be = 4'hf);
        u_host_bus_model.write_reg({i, 2'b00}, d, be, resp);
        cmp({30'h0, resp}, {30'h0, er});
    endtask : wr
    task automatic rd_chk(input logic [5:0] i, input logic [31:0] e,
                          input logic [1:0] er = RESP_OKAY);
        u_host_bus_model.read_reg({i, 2'b00}, rd, resp);
        cmp(rd, e);
        cmp({30'h0, resp}, {30'h0, er});
    endtask : rd_chk
    // One raw sample in, corrected sample checked one cycle later
    task automatic sample(input logic [23:0] x, input logic [23:0] e);
        @(posedge sys_clk);
        raw_valid <= 1'b1;
        raw_data  <= x;
        @(posedge sys_clk);
        raw_valid <= 1'b0;
        #1;
        cmp({out_valid, 7'h00, out_data}, {8'h80, e});
    endtask : sample
    task automatic summarize();
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    initial begin
        {global_dc_block_setting, checksum_load, raw_valid} = 3'b000;
        checksum_value = 16'h0000;
        raw_data = 24'h000000;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_chk(IDX_CONFIG, 32'h0000_0000);
        rd_chk(IDX_OFFSET_HIGH, 32'h0000_0000);
        rd_chk(IDX_OFFSET_LOW, 32'h0000_0000);
        rd_chk(IDX_GAIN_HIGH, 32'h0000_8000);
        rd_chk(IDX_GAIN_LOW, 32'h0000_0000);
        rd_chk(IDX_CHECKSUM, 32'h0000_0000);
        // Top and bottom bit first, then all-ones writes; reserved bits and read-only places stay zero
        wr(IDX_OFFSET_HIGH, 32'h0000_8001);
        rd_chk(IDX_OFFSET_HIGH, 32'h0000_8001);
        // Upper lane only, then lower lane only on a low register
        wr(IDX_OFFSET_HIGH, 32'h0000_7e7e, RESP_OKAY, 4'h2);
        rd_chk(IDX_OFFSET_HIGH, 32'h0000_7e01);
        wr(IDX_OFFSET_LOW, 32'h0000_ffff);
        rd_chk(IDX_OFFSET_LOW, 32'h0000_ff00);
        wr(IDX_OFFSET_LOW, 32'h0000_1234, RESP_OKAY, 4'h1);
        rd_chk(IDX_OFFSET_LOW, 32'h0000_ff00);
        wr(IDX_GAIN_HIGH, 32'h0000_ffff);
        rd_chk(IDX_GAIN_HIGH, 32'h0000_ffff);
        wr(IDX_GAIN_LOW, 32'h0000_ffff);
        rd_chk(IDX_GAIN_LOW, 32'h0000_ff00);
        wr(IDX_CONFIG, 32'h0000_ffff);
        rd_chk(IDX_CONFIG, 32'h0000_ffc7);
        wr(IDX_CHECKSUM, 32'h0000_ffff);
        rd_chk(IDX_CHECKSUM, 32'h0000_0000);
        wr(6'h3f, 32'h0000_ffff, RESP_SLVERR);
        rd_chk(6'h3f, 32'h0000_0000, RESP_SLVERR);
        @(posedge sys_clk);
        checksum_value <= 16'h5a5a;
        checksum_load  <= 1'b1;
        @(posedge sys_clk);
        checksum_load  <= 1'b0;
        rd_chk(IDX_CHECKSUM, 32'h0000_5a5a);
        // Every input route, with DC block bit and global setting swept
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk);
            global_dc_block_setting <= s[1];
            wr(IDX_CONFIG, {16'h0000, 10'h200, 3'b000, s[0], s[1:0]});
            cmp({22'h0, ch7_phase_delay}, 32'h0000_0200);
            cmp({31'h0, ch7_dc_block_on}, {31'h0, s[1] & ~s[0]});
            cmp({28'h0, ch7_test_neg, ch7_test_pos, ch7_short_inputs,
                 ch7_use_pins}, 32'h1 << s);
        end
        // Offset -1 with gain 1.5, then offset 10h with unity gain
        wr(IDX_OFFSET_HIGH, 32'h0000_ffff);
        wr(IDX_OFFSET_LOW, 32'h0000_ff00);
        wr(IDX_GAIN_HIGH, 32'h0000_c000);
        wr(IDX_GAIN_LOW, 32'h0000_0000);
        sample(24'h000007, 24'h00000c);
        wr(IDX_OFFSET_HIGH, 32'h0000_0000);
        wr(IDX_OFFSET_LOW, 32'h0000_1000);
        wr(IDX_GAIN_HIGH, 32'h0000_8000);
        sample(24'h000100, 24'h0000f0);
        sample(24'hfffff0, 24'hffffe0);
        // Gain just under 2.0 drives both extremes into saturation
        wr(IDX_GAIN_HIGH, 32'h0000_ffff);
        wr(IDX_GAIN_LOW, 32'h0000_ff00);
        sample(24'h7fffff, 24'h7fffff);
        sample(24'h800000, 24'h800000);
        summarize();
    end
endmodule : test_cal_regs
